//--- dcr_fifo_model.sv
// behavioural fifo that answers the bank's reset pulse with a done strobe
// assumes the bench sets the reload delay before each request
`timescale 1ns/100ps
module dcr_fifo_model
(
  input  wire logic       ref_clk_i,  // system clock
  input  wire logic       rst_i,      // synchronous reset, high
  input  wire logic       fifo_rst_i, // reset pulse from the bank
  input  wire logic [3:0] dly_i,      // reload time in cycles
  output logic            done_o      // one-cycle reload finished strobe
);
  logic [4:0] cnt_reg;     // reload countdown
  logic       was_rst_reg; // pulse seen last cycle

  initial done_o = 1'b0;

  // reload starts when the pulse ends, done strobes when the count runs out
  always @(posedge ref_clk_i)
  begin
    was_rst_reg <= fifo_rst_i;
    done_o      <= 1'b0;
    if (rst_i)
      cnt_reg <= 5'h00;
    else if (was_rst_reg && !fifo_rst_i)
      cnt_reg <= {1'b0, dly_i} + 5'h01;
    else if (cnt_reg != 5'h00)
    begin
      cnt_reg <= cnt_reg - 5'h01;
      done_o  <= (cnt_reg == 5'h01);
    end
  end
endmodule

//--- dcr_fifo_reset.sv
// fifo reset handshake: turns a software request into a reset pulse and ack
// assumes fifo_done_i is the fifo reporting that its pointers were reloaded
`timescale 1ns/100ps
module dcr_fifo_reset
(
  input  wire logic ref_clk_i,   // system clock
  input  wire logic rst_i,       // synchronous reset, high
  input  wire logic req_i,       // request bit as held in the register
  input  wire logic fifo_done_i, // fifo finished its reload
  output logic      fifo_rst_o,  // reset pulse to the fifo
  output logic      ack_o        // acknowledge bit
);
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT, ST_ACK} dcr_hs_e;
  dcr_hs_e                    state_reg;  // handshake state
  logic [1:0]                 cnt_reg;    // pulse length counter

  // handshake sequencer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 2'h0;
      fifo_rst_o <= 1'b0;
      ack_o      <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          // new request starts the fifo reset pulse
          if (req_i)
          begin
            state_reg  <= ST_PULSE;
            fifo_rst_o <= 1'b1; // RULE3
            cnt_reg    <= 2'h0;
          end
        end
        ST_PULSE:
        begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == 2'(dcr_pkg::RESET_PULSE_CYC - 1))
          begin
            fifo_rst_o <= 1'b0;
            state_reg  <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // fifo reload complete: report acknowledge
          if (fifo_done_i)
          begin
            ack_o     <= 1'b1; // RULE3
            state_reg <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          // ack stays until software drops the request
          if (!req_i)
          begin
            ack_o     <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ack only follows a request
  ack_cause_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
    $rose(ack_o) |-> $past(req_i))
    else $error("ack rose without a request");

  // reset pulse stands two cycles, then drops
  sequence pulse_hold_s;
    fifo_rst_o [*2] ##1 !fifo_rst_o;
  endsequence
  pulse_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
    $rose(fifo_rst_o) |-> pulse_hold_s)
    else $error("fifo reset pulse length wrong");

  // ack drops the cycle after software withdraws the request
  ack_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE3
    ack_o && !req_i |=> !ack_o)
    else $error("ack outlived its request");
endmodule

//--- dcr_pkg.sv
// register map, field positions and carrier types for the datapath config bank
// assumes an 8-bit register access port driven by the serial-port decoder
//
// Notes on behaviour
// [RULE1] level readback: integer [6:4], fraction [2:0]
// [RULE2] reported level within two conversion clocks
// [RULE3] bit0 requests fifo reset, bit1 acknowledges
// [RULE4] format bit7: twos complement or offset binary
// [RULE5] pairing bit6: I with next or prior Q
// [RULE6] bit5 reverses input port bit order
// [RULE7] format bit0: word 16-bit or byte 8-bit
// [RULE8] bit7 enables inverse sinc droop corrector
// [RULE9] bit6 oscillator enable, bit1 image side
// [RULE10] bit5 enables gain and offset correction
// [RULE11] bit4 enables phase correction
// [RULE12] bit2 enables quarter-rate mixer
// [RULE13] bit0 sends I to both converters
// [RULE14] interpolation code selects halfband stages
// [RULE15] 0x29 holds low threshold byte
// [RULE16] all control registers reset to 0x00
// [RULE17] integer in data periods, fraction in clocks
// [RULE18] 0x2A bits 4:0 hold upper threshold
// [RULE19] interpolation code 01 is reserved
// [RULE20] writes to read-only bits are ignored
package dcr_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LEVEL_RB  = 8'h24;
  localparam logic [7:0] ADDR_FIFO_CTL  = 8'h25;
  localparam logic [7:0] ADDR_FORMAT    = 8'h26;
  localparam logic [7:0] ADDR_DATAPATH  = 8'h27;
  localparam logic [7:0] ADDR_INTERP    = 8'h28;
  localparam logic [7:0] ADDR_THR_LOW   = 8'h29;
  localparam logic [7:0] ADDR_THR_HIGH  = 8'h2A;
  localparam logic [7:0] REG_RESET_VAL  = 8'h00;
  // fifo control fields
  localparam int FIFO_REQ_BIT = 0;
  localparam int FIFO_ACK_BIT = 1;
  // format fields
  localparam int FMT_BINARY_BIT  = 7;
  localparam int FMT_PAIR_BIT    = 6;
  localparam int FMT_INVERT_BIT  = 5;
  localparam int FMT_BYTE_BIT    = 0;
  localparam logic [7:0] FMT_MASK = 8'hE1;
  // datapath fields
  localparam int DP_SINC_BIT   = 7;
  localparam int DP_OSC_BIT    = 6;
  localparam int DP_GAIN_BIT   = 5;
  localparam int DP_PHASE_BIT  = 4;
  localparam int DP_FS4_BIT    = 2;
  localparam int DP_IMAGE_BIT  = 1;
  localparam int DP_DUP_BIT    = 0;
  localparam logic [7:0] DP_MASK   = 8'hF7;
  localparam logic [7:0] INTERP_MASK = 8'h03;
  localparam logic [7:0] THR_HIGH_MASK = 8'h1F;
  // level readback field positions
  localparam int LVL_INT_LSB  = 4;
  localparam int LVL_FRAC_LSB = 0;
  localparam int LVL_W        = 3;
  localparam int THR_W        = 13;
  // interpolation codes
  localparam logic [1:0] INTERP_2X = 2'h0;
  localparam logic [1:0] INTERP_RSV = 2'h1;
  localparam logic [1:0] INTERP_4X = 2'h2;
  localparam logic [1:0] INTERP_8X = 2'h3;
  // fifo reset pulse length, in clock cycles
  localparam int RESET_PULSE_CYC = 2;

  // datapath control bundle handed to the arithmetic
  typedef struct packed {
    logic       droop_corrector_on;
    logic       carrier_osc_on;
    logic       gain_offset_corr_on;
    logic       phase_corr_on;
    logic       quarter_rate_mixer_on;
    logic       image_side_sel;
    logic       duplicate_i_channel;
    logic       halfband_stage_one;
    logic       halfband_stage_two;
    logic       halfband_stage_three;
    logic       interp_reserved;
  } dcr_path_s;

  // input format bundle handed to the input port
  typedef struct packed {
    logic offset_binary;
    logic pair_prior_q;
    logic reverse_bits;
    logic byte_mode;
  } dcr_format_s;

  // register access strobe bundle
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dcr_access_s;
endpackage

//--- dcr_regs.sv
// datapath configuration register bank with fifo level readback
// assumes the serial-port decoder presents one-cycle write strobes and
// samples rdata the cycle after the address is held
`timescale 1ns/100ps
module dcr_regs
#(
  parameter int LVL_W = dcr_pkg::LVL_W // width of each level part
)
(
  input  wire logic                  ref_clk_i,       // system clock, 40 MHz
  input  wire logic                  rst_i,           // synchronous reset, high
  input  wire dcr_pkg::dcr_access_s  acc_i,           // register access
  input  wire logic [LVL_W-1:0]      level_int_i,     // measured integer level
  input  wire logic [LVL_W-1:0]      level_frac_i,    // measured fraction level
  input  wire logic                  fifo_done_i,     // fifo reload finished
  input  wire logic [15:0]           data_pins_i,     // raw input data port
  output logic [7:0]                 rdata_o,         // read data
  output logic                       fifo_rst_o,      // fifo reset pulse
  output dcr_pkg::dcr_format_s       format_o,        // input format controls
  output dcr_pkg::dcr_path_s         path_o,          // datapath controls
  output logic [dcr_pkg::THR_W-1:0]  power_thresh_o,  // protection threshold
  output logic [15:0]                port_data_o      // bit-ordered input word
);
  logic [7:0]       fifo_ctl_reg;   // request bit storage
  logic [7:0]       format_reg;     // input format select
  logic [7:0]       datapath_reg;   // datapath feature enables
  logic [7:0]       interp_reg;     // interpolation select
  logic [7:0]       thr_low_reg;    // threshold low byte
  logic [7:0]       thr_high_reg;   // threshold high bits
  logic [7:0]       level_reg;      // captured level readback
  logic             ack_w;          // handshake acknowledge
  logic             fifo_rst_w;     // handshake reset pulse
  logic [7:0]       rdata_next;     // read mux result
  dcr_pkg::dcr_path_s   path_next;  // decoded datapath controls
  dcr_pkg::dcr_format_s format_next;// decoded format controls
  logic [15:0]      port_next;      // reordered data word

  // write hit test, shared by every register
  function automatic logic hit(input dcr_pkg::dcr_access_s a, input logic [7:0] addr);
    hit = a.wr && (a.addr == addr);
  endfunction

  // bit reversal of a 16-bit word
  function automatic logic [15:0] rev16(input logic [15:0] d);
    for (int i = 0; i < 16; i++)
      rev16[i] = d[15 - i];
  endfunction

  // fifo control: only the request bit is writable
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      fifo_ctl_reg <= dcr_pkg::REG_RESET_VAL; // RULE16
    else if (hit(acc_i, dcr_pkg::ADDR_FIFO_CTL))
      fifo_ctl_reg <= acc_i.wdata & 8'h01; // RULE20
  end

  // input format register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      format_reg <= dcr_pkg::REG_RESET_VAL; // RULE16
    else if (hit(acc_i, dcr_pkg::ADDR_FORMAT))
      format_reg <= acc_i.wdata & dcr_pkg::FMT_MASK;
  end

  // datapath enables register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      datapath_reg <= dcr_pkg::REG_RESET_VAL; // RULE16
    else if (hit(acc_i, dcr_pkg::ADDR_DATAPATH))
      datapath_reg <= acc_i.wdata & dcr_pkg::DP_MASK;
  end

  // interpolation register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      interp_reg <= dcr_pkg::REG_RESET_VAL; // RULE16
    else if (hit(acc_i, dcr_pkg::ADDR_INTERP))
      interp_reg <= acc_i.wdata & dcr_pkg::INTERP_MASK;
  end

  // threshold registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      thr_low_reg  <= dcr_pkg::REG_RESET_VAL; // RULE16
      thr_high_reg <= dcr_pkg::REG_RESET_VAL;
    end
    else
    begin
      if (hit(acc_i, dcr_pkg::ADDR_THR_LOW))
        thr_low_reg <= acc_i.wdata; // RULE15
      if (hit(acc_i, dcr_pkg::ADDR_THR_HIGH))
        thr_high_reg <= acc_i.wdata & dcr_pkg::THR_HIGH_MASK; // RULE18
    end
  end

  // level capture: integer in data periods, fraction in clocks
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      level_reg <= dcr_pkg::REG_RESET_VAL;
    else
    begin
      level_reg <= 8'h00;
      level_reg[dcr_pkg::LVL_INT_LSB +: LVL_W]  <= level_int_i;  // RULE1 RULE17
      level_reg[dcr_pkg::LVL_FRAC_LSB +: LVL_W] <= level_frac_i; // RULE1 RULE2
    end
  end

  // reset handshake engine
  dcr_fifo_reset u_hs
  (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .req_i       (fifo_ctl_reg[dcr_pkg::FIFO_REQ_BIT]), // RULE3
    .fifo_done_i (fifo_done_i),
    .fifo_rst_o  (fifo_rst_w),
    .ack_o       (ack_w)
  );

  // read mux
  always_comb
  begin
    rdata_next = 8'h00;
    case (acc_i.addr)
      dcr_pkg::ADDR_LEVEL_RB: rdata_next = level_reg; // RULE1
      dcr_pkg::ADDR_FIFO_CTL:
      begin
        rdata_next = fifo_ctl_reg;
        rdata_next[dcr_pkg::FIFO_ACK_BIT] = ack_w; // RULE3
      end
      dcr_pkg::ADDR_FORMAT:   rdata_next = format_reg;
      dcr_pkg::ADDR_DATAPATH: rdata_next = datapath_reg;
      dcr_pkg::ADDR_INTERP:   rdata_next = interp_reg;
      dcr_pkg::ADDR_THR_LOW:  rdata_next = thr_low_reg;
      dcr_pkg::ADDR_THR_HIGH: rdata_next = thr_high_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  // format decode
  always_comb
  begin
    format_next.offset_binary = format_reg[dcr_pkg::FMT_BINARY_BIT]; // RULE4
    format_next.pair_prior_q  = format_reg[dcr_pkg::FMT_PAIR_BIT];   // RULE5
    format_next.reverse_bits  = format_reg[dcr_pkg::FMT_INVERT_BIT]; // RULE6
    format_next.byte_mode     = format_reg[dcr_pkg::FMT_BYTE_BIT];   // RULE7
  end

  // input port reordering: reversed port puts msb line on bit 0
  always_comb
  begin
    port_next = format_reg[dcr_pkg::FMT_INVERT_BIT] ? rev16(data_pins_i) // RULE6
                                                    : data_pins_i;
  end

  // datapath decode
  always_comb
  begin
    path_next.droop_corrector_on    = datapath_reg[dcr_pkg::DP_SINC_BIT];  // RULE8
    path_next.carrier_osc_on        = datapath_reg[dcr_pkg::DP_OSC_BIT];   // RULE9
    path_next.image_side_sel        = datapath_reg[dcr_pkg::DP_IMAGE_BIT]; // RULE9
    path_next.gain_offset_corr_on   = datapath_reg[dcr_pkg::DP_GAIN_BIT];  // RULE10
    path_next.phase_corr_on         = datapath_reg[dcr_pkg::DP_PHASE_BIT]; // RULE11
    path_next.quarter_rate_mixer_on = datapath_reg[dcr_pkg::DP_FS4_BIT];   // RULE12
    path_next.duplicate_i_channel   = datapath_reg[dcr_pkg::DP_DUP_BIT];   // RULE13
    // halfband chain from the interpolation code
    path_next.halfband_stage_one    = 1'b1; // RULE14
    path_next.halfband_stage_two    = 1'b0;
    path_next.halfband_stage_three  = 1'b0;
    path_next.interp_reserved       = 1'b0;
    case (interp_reg[1:0])
      dcr_pkg::INTERP_2X: ;
      dcr_pkg::INTERP_4X: path_next.halfband_stage_two = 1'b1; // RULE14
      dcr_pkg::INTERP_8X:
      begin
        path_next.halfband_stage_two   = 1'b1; // RULE14
        path_next.halfband_stage_three = 1'b1;
      end
      default: path_next.interp_reserved = 1'b1; // RULE19
    endcase
  end

  // registered outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o        <= 8'h00;
      fifo_rst_o     <= 1'b0;
      format_o       <= '0;
      path_o         <= '0;
      power_thresh_o <= '0;
      port_data_o    <= 16'h0000;
    end
    else
    begin
      rdata_o        <= rdata_next;
      fifo_rst_o     <= fifo_rst_w;
      format_o       <= format_next;
      path_o         <= path_next;
      power_thresh_o <= {thr_high_reg[4:0], thr_low_reg}; // RULE15 RULE18
      port_data_o    <= port_next;
    end
  end

  // read-only readback is never stored from a write
  sequence level_write_s;
    hit(acc_i, dcr_pkg::ADDR_LEVEL_RB);
  endsequence
  ro_ignore_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE20
    level_write_s |=> level_reg == {1'b0, $past(level_int_i), 1'b0, $past(level_frac_i)})
    else $error("readback picked up write data");
  // threshold output follows both bytes two cycles on
  thr_path_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE18
    hit(acc_i, dcr_pkg::ADDR_THR_HIGH) |=> ##1 power_thresh_o[12:8] == $past(acc_i.wdata[4:0], 2))
    else $error("threshold high bits wrong");
  thr_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE15
    hit(acc_i, dcr_pkg::ADDR_THR_LOW) |=> ##1 power_thresh_o[7:0] == $past(acc_i.wdata, 2))
    else $error("threshold low byte wrong");
  dup_i_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE13
    hit(acc_i, dcr_pkg::ADDR_DATAPATH) |=> ##1
      path_o.duplicate_i_channel == $past(acc_i.wdata[0], 2))
    else $error("duplicate control mismatch");
  sinc_en_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE8
    hit(acc_i, dcr_pkg::ADDR_DATAPATH) |=> ##1
      path_o.droop_corrector_on == $past(acc_i.wdata[7], 2))
    else $error("droop enable mismatch");
  hb_chain_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE14
    path_o.halfband_stage_three |-> path_o.halfband_stage_two && path_o.halfband_stage_one)
    else $error("halfband chain broken");
  bit_rev_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE6
    format_reg[dcr_pkg::FMT_INVERT_BIT] |=> port_data_o[0] == $past(data_pins_i[15]))
    else $error("bit reversal wrong");
  byte_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE7
    hit(acc_i, dcr_pkg::ADDR_FORMAT) |=> ##1 format_o.byte_mode == $past(acc_i.wdata[0], 2))
    else $error("bus width select mismatch");

  // write strobes to the two decoded control registers
  sequence fmt_write_s;
    hit(acc_i, dcr_pkg::ADDR_FORMAT);
  endsequence
  sequence dp_write_s;
    hit(acc_i, dcr_pkg::ADDR_DATAPATH);
  endsequence

  // sample coding follows format bit 7
  fmt_binary_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE4
    fmt_write_s |=> ##1 format_o.offset_binary == $past(acc_i.wdata[7], 2))
    else $error("sample coding select mismatch");
  // i/q pairing follows format bit 6
  fmt_pair_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE5
    fmt_write_s |=> ##1 format_o.pair_prior_q == $past(acc_i.wdata[6], 2))
    else $error("pairing select mismatch");
  // oscillator enable and image side
  osc_image_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE9
    dp_write_s |=> ##1 path_o.carrier_osc_on == $past(acc_i.wdata[6], 2)
      && path_o.image_side_sel == $past(acc_i.wdata[1], 2))
    else $error("oscillator controls mismatch");
  // gain and offset correction enable
  gain_corr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE10
    dp_write_s |=> ##1 path_o.gain_offset_corr_on == $past(acc_i.wdata[5], 2))
    else $error("gain correction enable mismatch");
  // phase correction enable
  phase_corr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE11
    dp_write_s |=> ##1 path_o.phase_corr_on == $past(acc_i.wdata[4], 2))
    else $error("phase correction enable mismatch");
  // quarter-rate mixer enable
  quarter_mix_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE12
    dp_write_s |=> ##1 path_o.quarter_rate_mixer_on == $past(acc_i.wdata[2], 2))
    else $error("mixer enable mismatch");
  // 4x code uses the first two halfband stages only
  hb_four_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE14
    interp_reg[1:0] == dcr_pkg::INTERP_4X |=>
      path_o.halfband_stage_two && !path_o.halfband_stage_three)
    else $error("4x halfband selection wrong");
  // every control register is cleared by reset
  reset_clear_a: assert property (@(posedge ref_clk_i) // RULE16
    rst_i |=> format_reg == dcr_pkg::REG_RESET_VAL && datapath_reg == dcr_pkg::REG_RESET_VAL
      && interp_reg == dcr_pkg::REG_RESET_VAL && thr_low_reg == dcr_pkg::REG_RESET_VAL
      && thr_high_reg == dcr_pkg::REG_RESET_VAL && fifo_ctl_reg == dcr_pkg::REG_RESET_VAL)
    else $error("register survived reset");
  // readback byte tracks both level parts every cycle
  level_track_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE1 RULE17
    1'b1 |=> level_reg == {1'b0, $past(level_int_i), 1'b0, $past(level_frac_i)})
    else $error("level readback stale");
  // port word passes unchanged while reversal is off
  bit_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE6
    !format_reg[dcr_pkg::FMT_INVERT_BIT] |=> port_data_o == $past(data_pins_i))
    else $error("port word altered");
endmodule

//--- dcr_regs_test.sv
// self-checking bench for the datapath configuration register bank
// assumes the fifo model answers each reset pulse after a set delay
`timescale 1ns/100ps
module dcr_regs_test;
  typedef struct packed {logic [2:0] kind; logic [15:0] val;} dcr_note_s;

  logic                 ref_clk_i = 1'b0;  // 40 MHz clock
  logic                 rst_i     = 1'b1;  // reset, high
  dcr_pkg::dcr_access_s acc_i     = '0;    // register access
  logic [2:0]           lvl_int   = 3'h0;  // level integer part
  logic [2:0]           lvl_frac  = 3'h0;  // level fraction part
  logic [15:0]          pins      = 16'h0000; // raw data port
  logic [15:0]          pins_rev;          // port word with its bit order swapped
  logic [3:0]           dly       = 4'h0;  // fifo reload delay
  logic                 fifo_done;         // from the fifo model
  logic [7:0]           rdata;             // read data
  logic                 fifo_rst;          // reset pulse
  dcr_pkg::dcr_format_s fmt;               // format controls
  dcr_pkg::dcr_path_s   path;              // datapath controls
  logic [12:0]          thr;               // threshold
  logic [15:0]          pdata;             // ordered data word
  logic                 look      = 1'b0;  // monitor drains notes
  logic [7:0]           fm, dp, ip, tl, th; // shadow register values
  int                   errors      = 0;
  int                   checks_done = 0;
  int                   n_hi;
  dcr_note_s            notes [$];         // expected results, oldest first
  dcr_note_s            n;

  always #12.5 ref_clk_i = ~ref_clk_i;

  dcr_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .acc_i(acc_i), .level_int_i(lvl_int),
    .level_frac_i(lvl_frac), .fifo_done_i(fifo_done), .data_pins_i(pins), .rdata_o(rdata),
    .fifo_rst_o(fifo_rst), .format_o(fmt), .path_o(path), .power_thresh_o(thr),
    .port_data_o(pdata));

  dcr_fifo_model fifo (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .fifo_rst_i(fifo_rst),
    .dly_i(dly), .done_o(fifo_done));

  // count and report one comparison
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // output picked by the kind of a note
  function automatic logic [15:0] seen_of(input logic [2:0] k);
    case (k)
      3'h0: seen_of = {8'h00, rdata};
      3'h1: seen_of = {5'h00, path};
      3'h2: seen_of = {12'h000, fmt};
      3'h3: seen_of = {3'h0, thr};
      default: seen_of = pdata;
    endcase
  endfunction

  // monitor: compares every pending note once results are settled
  always @(negedge ref_clk_i)
    if (look === 1'b1)
      while (notes.size() > 0)
      begin
        n = notes.pop_front();
        check(seen_of(n.kind), n.val);
      end

  task automatic note(input logic [2:0] k, input logic [15:0] v);
    notes.push_back({k, v});
  endtask

  task automatic settle;
    look = 1'b1;
    @(negedge ref_clk_i) #1 look = 1'b0;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) #2 acc_i = {1'b1, a, d};
    @(posedge ref_clk_i) #2 acc_i.wr = 1'b0;
  endtask

  // present an address and note the read data due one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i) #2 acc_i.addr = a;
    @(posedge ref_clk_i) #2 note(3'h0, {8'h00, e});
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    wr(a, d);
    rd(a, d & m);
    settle;
  endtask

  // expected datapath bundle from the shadow registers
  function automatic logic [15:0] path_exp;
    path_exp = {5'h00, dp[7:4], dp[2:0], 1'b1, ip[1], ip[1:0] == 2'h3, ip[1:0] == 2'h1};
  endfunction

  // watchdog: the whole run takes a few hundred cycles
  initial
  begin
    #(25 * 20000);
    errors++;
    give_verdict;
  end

  initial
  begin
    void'($urandom(32'hED39));
    repeat (10) @(posedge ref_clk_i);
    #2 rst_i = 1'b0;
    // every register reads zero after reset
    for (int a = 8'h24; a <= 8'h2A; a++)
    begin
      rd(8'(a), 8'h00);
      settle;
    end
    // random contents, interpolation codes 00, 10 and 11 in turn
    for (int i = 0; i < 6; i++)
    begin
      fm = 8'($urandom);
      dp = 8'($urandom);
      // code 01 is never programmed
      ip = (8'($urandom) & 8'hFC) | ((i % 3 == 0) ? 8'h00 :
            (i % 3 == 1) ? 8'h02 : 8'h03);
      tl = 8'($urandom);
      th = 8'($urandom);
      chk_reg(dcr_pkg::ADDR_FORMAT, fm, dcr_pkg::FMT_MASK);
      chk_reg(dcr_pkg::ADDR_DATAPATH, dp, dcr_pkg::DP_MASK);
      chk_reg(dcr_pkg::ADDR_INTERP, ip, dcr_pkg::INTERP_MASK);
      chk_reg(dcr_pkg::ADDR_THR_LOW, tl, 8'hFF);
      chk_reg(dcr_pkg::ADDR_THR_HIGH, th, dcr_pkg::THR_HIGH_MASK);
      note(3'h2, {12'h000, fm[7], fm[6], fm[5], fm[0]});
      note(3'h1, path_exp());
      note(3'h3, {3'h0, th[4:0], tl});
      settle;
    end
    // reset in mid-run clears every register and every output but halfband stage one
    @(posedge ref_clk_i) #2 rst_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #2 rst_i = 1'b0;
    dp = 8'h00;
    ip = 8'h00;
    for (int a = 8'h24; a <= 8'h2A; a++)
    begin
      rd(8'(a), 8'h00);
      settle;
    end
    note(3'h1, path_exp());
    note(3'h2, 16'h0000);
    note(3'h3, 16'h0000);
    settle;
    // unmapped place, then level readback that ignores writes
    chk_reg(8'h30, 8'($urandom), 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      lvl_int  = 3'($urandom);
      lvl_frac = 3'($urandom);
      wr(dcr_pkg::ADDR_LEVEL_RB, 8'hFF);
      rd(dcr_pkg::ADDR_LEVEL_RB, {1'b0, lvl_int, 1'b0, lvl_frac});
      settle;
    end
    // fifo reset handshake with a prompt and a slow fifo
    for (int i = 0; i < 2; i++)
    begin
      dly  = (i == 0) ? 4'h0 : 4'h9;
      n_hi = 0;
      wr(dcr_pkg::ADDR_FIFO_CTL, 8'h03);
      for (int k = 0; k < 40; k++)
      begin
        @(posedge ref_clk_i) #2 acc_i.addr = dcr_pkg::ADDR_FIFO_CTL;
        if (fifo_rst === 1'b1)
          n_hi++;
        if (rdata[1] === 1'b1)
          break;
      end
      check(16'(n_hi), 16'(dcr_pkg::RESET_PULSE_CYC));
      rd(dcr_pkg::ADDR_FIFO_CTL, 8'h03);
      settle;
      wr(dcr_pkg::ADDR_FIFO_CTL, 8'hFE);
      repeat (2) @(posedge ref_clk_i);
      rd(dcr_pkg::ADDR_FIFO_CTL, 8'h00);
      settle;
    end
    // input port word in both bit orders
    for (int r = 0; r < 2; r++)
    begin
      wr(dcr_pkg::ADDR_FORMAT, (r == 1) ? 8'h20 : 8'h00);
      repeat (2) @(posedge ref_clk_i);
      @(posedge ref_clk_i) #2 pins = 16'($urandom);
      pins_rev = {<<{pins}};
      @(posedge ref_clk_i) #2 note(3'h4, (r == 1) ? pins_rev : pins);
      settle;
    end
    give_verdict;
  end
endmodule
